// File: cmd_relay.sv
// Purpose: Command interpreter of the network master: parameter-set copy and broadcast relay
// Assumes: Host characters arrive as a stream with last marking the command end
// Notes:   Slave replies are buffered and returned one whole response at a time
//
// Function
// - Answer a good parameter-set copy with param_ok_ack, a failure with another code.
// - Broadcast command forwards the appended command to every slave.
// - Version replies from slaves after a broadcast query go back to the host.
// - Acknowledgements after broadcast are exactly those the slaves produce.
// - The master sends no acknowledgement of its own for broadcast.
// - No separators between command and parameters; either letter case accepted.
// - Every acknowledgement to the host carries the two-character producer address.
`timescale 1ns/1ps
module cmd_relay #(
  parameter logic [15:0] master_addr = relay_pkg::MASTER_ADDR,
  parameter int          fifo_depth  = relay_pkg::FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire relay_pkg::char_t  host_rx,
  input  wire logic              host_rx_valid,
  output logic                   host_rx_ready,
  output relay_pkg::char_t       host_tx,
  output logic                   host_tx_valid,
  input  wire logic              host_tx_ready,
  output relay_pkg::char_t       net_tx,
  output logic                   net_tx_valid,
  input  wire logic              net_tx_ready,
  input  wire relay_pkg::resp_t  net_rx,
  input  wire logic              net_rx_valid,
  output logic                   net_rx_ready,
  output logic                   ps_req,
  output logic [1:0]             ps_src,
  output logic [1:0]             ps_dst,
  input  wire logic              ps_done,
  input  wire logic [3:0]        ps_code
);
  relay_pkg::parse_state_t p_ff, nxt_p;
  relay_pkg::tx_state_t    t_ff, nxt_t;
  relay_pkg::char_t        net_tx_ff, nxt_net_tx, host_tx_ff, nxt_host_tx;
  relay_pkg::resp_t        fifo_out;
  logic                    net_valid_ff, nxt_net_valid, rx_ready_ff, nxt_rx_ready;
  logic                    host_valid_ff, nxt_host_valid;
  logic                    ps_req_ff, nxt_ps_req, ack_pend_ff, nxt_ack_pend;
  logic [1:0]              src_ff, nxt_src, dst_ff, nxt_dst;
  logic [3:0]              code_ff, nxt_code;
  logic [7:0]              addr0_ff, nxt_addr0;
  logic [2:0]              idx_ff, nxt_idx;
  logic                    take, ack_take, fifo_valid, fifo_pop, tx_slot;
  logic [7:0]              up, dig;
  logic                    dig_ok;

  resp_fifo #(
    .WIDTH ($bits(relay_pkg::resp_t)),
    .DEPTH (fifo_depth)
  ) u_resp_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   (net_rx),
    .in_valid  (net_rx_valid),
    .in_ready  (net_rx_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Command parser
  always_comb begin
    take          = host_rx_valid && rx_ready_ff;
    up            = host_rx.data & relay_pkg::CASE_MASK;
    dig           = host_rx.data - relay_pkg::CH_0;
    dig_ok        = host_rx.data >= relay_pkg::CH_0 && dig <= relay_pkg::MAX_PSET;
    nxt_p         = p_ff;
    nxt_addr0     = addr0_ff;
    nxt_src       = src_ff;
    nxt_dst       = dst_ff;
    nxt_code      = code_ff;
    nxt_ps_req    = 1'b0;
    nxt_ack_pend  = ack_pend_ff && !ack_take;
    nxt_net_tx    = net_tx_ff;
    nxt_net_valid = net_valid_ff && !net_tx_ready;
    case (p_ff)
      relay_pkg::P_ADDR0: begin
        if (take) begin
          nxt_addr0 = host_rx.data;
          nxt_p     = host_rx.last ? relay_pkg::P_ADDR0 : relay_pkg::P_ADDR1;
        end
      end
      relay_pkg::P_ADDR1: begin
        if (take) begin
          if (host_rx.last) begin
            nxt_p = relay_pkg::P_ADDR0;
          end else if ({addr0_ff, host_rx.data} == master_addr) begin
            nxt_p = relay_pkg::P_CMD;
          end else begin
            nxt_p = relay_pkg::P_DROP;
          end
        end
      end
      relay_pkg::P_CMD: begin
        if (take) begin
          if (host_rx.last) begin
            nxt_p = relay_pkg::P_ADDR0;
          end else if (up == relay_pkg::CH_B) begin
            nxt_p = relay_pkg::P_BCAST;
          end else if (up == relay_pkg::CH_P) begin
            nxt_p = relay_pkg::P_PC1;
          end else begin
            nxt_p = relay_pkg::P_DROP;
          end
        end
      end
      relay_pkg::P_BCAST: begin
        // Whatever follows goes out unchecked, including its end mark
        if (take) begin
          nxt_net_tx    = host_rx;
          nxt_net_valid = 1'b1;
          nxt_p         = host_rx.last ? relay_pkg::P_ADDR0 : relay_pkg::P_BCAST;
        end
      end
      relay_pkg::P_PC1: begin
        if (take) begin
          if (host_rx.last) begin
            nxt_p = relay_pkg::P_ADDR0;
          end else begin
            nxt_p = (up == relay_pkg::CH_C) ? relay_pkg::P_PC_SRC : relay_pkg::P_DROP;
          end
        end
      end
      relay_pkg::P_PC_SRC: begin
        if (take) begin
          nxt_src  = dig[1:0];
          nxt_code = dig_ok ? relay_pkg::PS_OK : relay_pkg::PS_BAD_PARAM;
          nxt_p    = host_rx.last ? relay_pkg::P_ADDR0 : relay_pkg::P_PC_DST;
        end
      end
      relay_pkg::P_PC_DST: begin
        if (take) begin
          if (!host_rx.last) begin
            nxt_p = relay_pkg::P_DROP;
          end else if (dig_ok && code_ff == relay_pkg::PS_OK) begin
            nxt_dst    = dig[1:0];
            nxt_ps_req = 1'b1;
            nxt_p      = relay_pkg::P_PS_WAIT;
          end else begin
            // Bad set numbers never reach the store
            nxt_code     = relay_pkg::PS_BAD_PARAM;
            nxt_ack_pend = 1'b1;
            nxt_p        = relay_pkg::P_ACKW;
          end
        end
      end
      relay_pkg::P_PS_WAIT: begin
        if (ps_done) begin
          nxt_code     = ps_code;
          nxt_ack_pend = 1'b1;
          nxt_p        = relay_pkg::P_ACKW;
        end
      end
      relay_pkg::P_ACKW: begin
        if (ack_take) begin
          nxt_p = relay_pkg::P_ADDR0;
        end
      end
      relay_pkg::P_DROP: begin
        if (take && host_rx.last) begin
          nxt_p = relay_pkg::P_ADDR0;
        end
      end
      default: nxt_p = relay_pkg::P_ADDR0;
    endcase
    // Registered ready: broadcast waits until the one-byte slot is free
    case (nxt_p)
      relay_pkg::P_PS_WAIT, relay_pkg::P_ACKW: nxt_rx_ready = 1'b0;
      relay_pkg::P_BCAST:                      nxt_rx_ready = !nxt_net_valid;
      default:                                 nxt_rx_ready = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_ff         <= relay_pkg::P_ADDR0;
      addr0_ff     <= '0;
      src_ff       <= '0;
      dst_ff       <= '0;
      code_ff      <= '0;
      ps_req_ff    <= 1'b0;
      ack_pend_ff  <= 1'b0;
      net_tx_ff    <= '0;
      net_valid_ff <= 1'b0;
      rx_ready_ff  <= 1'b0;
    end else begin
      p_ff         <= nxt_p;
      addr0_ff     <= nxt_addr0;
      src_ff       <= nxt_src;
      dst_ff       <= nxt_dst;
      code_ff      <= nxt_code;
      ps_req_ff    <= nxt_ps_req;
      ack_pend_ff  <= nxt_ack_pend;
      net_tx_ff    <= nxt_net_tx;
      net_valid_ff <= nxt_net_valid;
      rx_ready_ff  <= nxt_rx_ready;
    end
  end

  // Host transmitter: switches source only between whole messages
  always_comb begin
    tx_slot        = !host_valid_ff || host_tx_ready;
    nxt_t          = t_ff;
    nxt_idx        = idx_ff;
    nxt_host_tx    = host_tx_ff;
    nxt_host_valid = host_valid_ff && !host_tx_ready;
    ack_take       = 1'b0;
    fifo_pop       = 1'b0;
    case (t_ff)
      relay_pkg::T_IDLE: begin
        nxt_idx = relay_pkg::IDX_ZERO;
        // Local answer first; it is short and the parser stalls on it
        if (ack_pend_ff) begin
          ack_take = 1'b1;
          nxt_t    = relay_pkg::T_ACK;
        end else if (fifo_valid) begin
          nxt_t = relay_pkg::T_RESP;
        end
      end
      relay_pkg::T_ACK: begin
        if (tx_slot) begin
          nxt_host_valid   = 1'b1;
          nxt_host_tx.last = 1'b0;
          nxt_idx          = idx_ff + 3'h1;
          case (idx_ff)
            relay_pkg::IDX_ZERO:    nxt_host_tx.data = master_addr[15:8];
            relay_pkg::IDX_ADDR_LO: nxt_host_tx.data = master_addr[7:0];
            relay_pkg::IDX_ACK_P:   nxt_host_tx.data = relay_pkg::CH_P;
            relay_pkg::IDX_ACK_S:   nxt_host_tx.data = relay_pkg::CH_S;
            default: begin
              nxt_host_tx.data = relay_pkg::CH_0 + {4'h0, code_ff};
              nxt_host_tx.last = 1'b1;
              nxt_t            = relay_pkg::T_IDLE;
            end
          endcase
        end
      end
      relay_pkg::T_RESP: begin
        if (tx_slot) begin
          nxt_host_valid   = 1'b1;
          nxt_host_tx.last = 1'b0;
          if (idx_ff == relay_pkg::IDX_ZERO) begin
            nxt_host_tx.data = fifo_out.addr[15:8];
            nxt_idx          = relay_pkg::IDX_ADDR_LO;
          end else if (idx_ff == relay_pkg::IDX_ADDR_LO) begin
            nxt_host_tx.data = fifo_out.addr[7:0];
            nxt_idx          = relay_pkg::IDX_ACK_P;
          end else if (fifo_valid) begin
            // Slave bytes pass untouched so the host sees their own answers
            fifo_pop    = 1'b1;
            nxt_host_tx = '{data: fifo_out.data, last: fifo_out.last};
            if (fifo_out.last) begin
              nxt_t = relay_pkg::T_IDLE;
            end
          end else begin
            nxt_host_valid = 1'b0;
          end
        end
      end
      default: nxt_t = relay_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_ff          <= relay_pkg::T_IDLE;
      idx_ff        <= '0;
      host_tx_ff    <= '0;
      host_valid_ff <= 1'b0;
    end else begin
      t_ff          <= nxt_t;
      idx_ff        <= nxt_idx;
      host_tx_ff    <= nxt_host_tx;
      host_valid_ff <= nxt_host_valid;
    end
  end

  assign host_rx_ready = rx_ready_ff;
  assign host_tx       = host_tx_ff;
  assign host_tx_valid = host_valid_ff;
  assign net_tx        = net_tx_ff;
  assign net_tx_valid  = net_valid_ff;
  assign ps_req        = ps_req_ff;
  assign ps_src        = src_ff;
  assign ps_dst        = dst_ff;
endmodule

// File: net_side.sv
// Purpose: Slaves and parameter store beside the relay
// Assumes: One slave response enters at a time
// Notes:   Idle lines show the inverse of the last value
`timescale 1ns/1ps
module net_side (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire relay_pkg::char_t net_tx,
  input  wire logic             net_tx_valid,
  output logic                  net_tx_ready,
  output relay_pkg::resp_t      net_rx,
  output logic                  net_rx_valid,
  input  wire logic             net_rx_ready,
  input  wire logic             ps_req,
  output logic                  ps_done,
  output logic [3:0]            ps_code
);
  logic             slow = 1'b0;
  logic [3:0]       code = 4'h0;
  int               n_req = 0;
  relay_pkg::char_t got[$];
  initial begin
    net_tx_ready = 1'b1;
    net_rx = '0;
    net_rx_valid = 1'b0;
    ps_done = 1'b0;
    ps_code = 4'hF;
  end
  always @(posedge ref_clk) begin
    if (rst_n && net_tx_valid && net_tx_ready)
      got.push_back(net_tx);
    if (ps_req)
      n_req++;
    #1 net_tx_ready <= slow ? ~net_tx_ready : 1'b1;
  end
  // Slow store on purpose, result a few cycles late
  always @(posedge ref_clk) begin
    if (ps_req) begin
      repeat (3) @(posedge ref_clk);
      #1 ps_done = 1'b1;
      ps_code = code;
      @(posedge ref_clk);
      #1 ps_done = 1'b0;
      ps_code = ~code;
    end
  end
  // Gives up after 10 refused cycles, n tells how many chars went in
  task automatic reply(input logic [15:0] a, input string s, output int n);
    logic ok;
    n = 0;
    for (int i = 0; i < s.len(); i++) begin
      net_rx <= '{a, s[i], i == s.len() - 1};
      net_rx_valid <= 1'b1;
      ok = 1'b0;
      repeat (10) if (!ok) begin
        @(posedge ref_clk);
        ok = net_rx_ready;
      end
      #1;
      if (!ok)
        break;
      n++;
    end
    net_rx_valid <= 1'b0;
    net_rx <= ~net_rx;
    // Idle edge before any following reply raises valid again
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// File: relay_checker.sv
// Purpose: Port-level checks of the command relay
// Assumes: Every address sent to the host starts with ASCII 0
// Notes:   Ack tracking expects one command in flight
`timescale 1ns/1ps
module relay_checker (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire relay_pkg::char_t host_tx,
  input wire logic             host_tx_valid,
  input wire logic             host_tx_ready,
  input wire relay_pkg::char_t net_tx,
  input wire logic             net_tx_valid,
  input wire logic             net_tx_ready,
  input wire logic             ps_req,
  input wire logic [1:0]       ps_src,
  input wire logic [1:0]       ps_dst,
  input wire logic             ps_done,
  input wire logic [3:0]       ps_code
);
  logic       start_ff;
  logic       wait_ff;
  logic       ack_ff;
  logic [3:0] code_ff;
  logic       take;
  assign take = host_tx_valid && host_tx_ready;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 1'b1;
      wait_ff  <= 1'b0;
      ack_ff   <= 1'b0;
      code_ff  <= 4'h0;
    end else begin
      if (take)
        start_ff <= host_tx.last;
      if (ps_req)
        wait_ff <= 1'b1;
      if (ps_done && wait_ff) begin
        wait_ff <= 1'b0;
        ack_ff  <= 1'b1;
        code_ff <= ps_code;
      end else if (take && host_tx.last)
        ack_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ps_pulse: assert property (ps_req |=> !ps_req)
    else $error("ps_req longer than one cycle");
  a_set_range: assert property (ps_req |-> ps_src <= 2'h2 && ps_dst <= 2'h2)
    else $error("set number out of range");
  a_set_stable: assert property (ps_req |=> $stable(ps_src) && $stable(ps_dst))
    else $error("set numbers moved");
  a_ack_soon: assert property (ps_done && wait_ff |-> ##[1:4] host_tx_valid)
    else $error("no ack after result");
  a_ack_code: assert property (take && host_tx.last && ack_ff |->
    host_tx.data == {4'h3, code_ff})
    else $error("ack code differs from result");
  a_addr_first: assert property (host_tx_valid && start_ff |-> host_tx.data == 8'h30)
    else $error("response lacks address");
  a_tx_hold: assert property (host_tx_valid && !host_tx_ready |=>
    host_tx_valid && $stable(host_tx))
    else $error("host char dropped");
  a_net_hold: assert property (net_tx_valid && !net_tx_ready |=>
    net_tx_valid && $stable(net_tx))
    else $error("net char dropped");
  a_tx_whole: assert property (take && !host_tx.last |=> host_tx_valid)
    else $error("response broken up");
endmodule
bind cmd_relay relay_checker i_relay_checker (
  .ref_clk, .rst_n, .host_tx, .host_tx_valid, .host_tx_ready, .net_tx, .net_tx_valid,
  .net_tx_ready, .ps_req, .ps_src, .ps_dst, .ps_done, .ps_code
);

// File: relay_pkg.sv
// Purpose: Shared constants and types for the network master command relay
// Assumes: Characters are 8-bit ASCII, one per stream beat
// Notes:   Letter compares go through case_mask so either case is accepted
package relay_pkg;
  localparam logic [7:0]  CH_B         = 8'h42;
  localparam logic [7:0]  CH_P         = 8'h50;
  localparam logic [7:0]  CH_C         = 8'h43;
  localparam logic [7:0]  CH_S         = 8'h53;
  localparam logic [7:0]  CH_0         = 8'h30;
  localparam logic [7:0]  CASE_MASK    = 8'hDF;
  localparam logic [7:0]  MAX_PSET     = 8'h02;
  localparam logic [3:0]  PS_OK        = 4'h0;
  localparam logic [3:0]  PS_BAD_PARAM = 4'h6;
  localparam logic [15:0] MASTER_ADDR  = 16'h3030;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [2:0]  IDX_ZERO     = 3'h0;
  localparam logic [2:0]  IDX_ADDR_LO  = 3'h1;
  localparam logic [2:0]  IDX_ACK_P    = 3'h2;
  localparam logic [2:0]  IDX_ACK_S    = 3'h3;
  localparam logic [2:0]  IDX_ACK_CODE = 3'h4;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } char_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        last;
  } resp_t;

  typedef enum logic [3:0] {
    P_ADDR0, P_ADDR1, P_CMD, P_BCAST, P_PC1, P_PC_SRC, P_PC_DST, P_PS_WAIT, P_ACKW, P_DROP
  } parse_state_t;

  typedef enum logic [1:0] {
    T_IDLE, T_ACK, T_RESP
  } tx_state_t;
endpackage

// File: resp_fifo.sv
// Purpose: Synchronous FIFO holding slave responses bound for the host
// Assumes: Single clock, depth a power of two
// Notes:   Ready and valid are flops, so full and empty lag nothing
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = relay_pkg::FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             in_ready_ff, out_valid_ff, nxt_in_ready, nxt_out_valid;
  logic             push, pop;

  always_comb begin
    push          = in_valid && in_ready_ff;
    pop           = out_ready && out_valid_ff;
    nxt_wr        = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd        = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt       = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_in_ready  = nxt_cnt != (AW+1)'(DEPTH);
    nxt_out_valid = nxt_cnt != '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff        <= '0;
      rd_ff        <= '0;
      cnt_ff       <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ff        <= nxt_wr;
      rd_ff        <= nxt_rd;
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
    end
  end

  // Storage has no reset; contents are only read once valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = mem[rd_ff];
endmodule

// File: tb.sv
// Purpose: Self-checking bench of the command relay
// Assumes: Host and slave addresses begin with ASCII 0
// Notes:   Host side stalls by toggling its ready
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic             ref_clk, rst_n, host_rx_valid, host_rx_ready, host_tx_valid;
  logic             host_tx_ready, net_tx_valid, net_tx_ready, net_rx_valid;
  logic             net_rx_ready, ps_req, ps_done, hold_tx, slow_tx;
  logic [1:0]       ps_src, ps_dst, src_seen, dst_seen;
  logic [3:0]       ps_code;
  relay_pkg::char_t host_rx, host_tx, net_tx;
  relay_pkg::resp_t net_rx;
  int               errors = 0;
  int               n_compared = 0;
  cmd_relay i_cmd_relay (.ref_clk, .rst_n, .host_rx, .host_rx_valid, .host_rx_ready,
    .host_tx, .host_tx_valid, .host_tx_ready, .net_tx, .net_tx_valid, .net_tx_ready,
    .net_rx, .net_rx_valid, .net_rx_ready, .ps_req, .ps_src, .ps_dst, .ps_done, .ps_code);
  net_side i_net_side (.ref_clk, .rst_n, .net_tx, .net_tx_valid, .net_tx_ready, .net_rx,
    .net_rx_valid, .net_rx_ready, .ps_req, .ps_done, .ps_code);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (ps_req) begin
      src_seen <= ps_src;
      dst_seen <= ps_dst;
    end
    #1 host_tx_ready <= hold_tx ? 1'b0 : (slow_tx ? ~host_tx_ready : 1'b1);
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      host_rx <= '{s[i], i == s.len() - 1};
      host_rx_valid <= 1'b1;
      do @(posedge ref_clk); while (!host_rx_ready);
      #1;
    end
    host_rx_valid <= 1'b0;
    host_rx <= ~host_rx;
    // One idle edge so a following call never re-raises valid in the same step
    @(posedge ref_clk);
    #1;
  endtask
  task automatic expect_resp(input string s);
    int w;
    for (int i = 0; i < s.len(); i++) begin
      w = 0;
      do begin
        @(posedge ref_clk);
        w++;
      end while (!(host_tx_valid && host_tx_ready) && w < 60);
      `CHK("host_tx", {s[i], i == s.len() - 1}, host_tx)
      #1;
    end
  endtask
  task automatic quiet(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(posedge ref_clk);
      seen += int'(host_tx_valid !== 1'b0);
    end
    #1;
    `CHK("quiet", 0, seen)
  endtask
  task automatic t_param;
    string      cmd[4] = '{"00PC20", "00pc01", "00Pc10", "00Pc10"};
    logic [3:0] cd[4] = '{4'h0, 4'h0, 4'h8, 4'h0};
    string      r;
    for (int k = 0; k < 4; k++) begin
      i_net_side.code = cd[k];
      r = "00PS0";
      r[4] = 8'h30 + cd[k];
      send(cmd[k]);
      expect_resp(r);
      `CHK("ps_set", {2'(cmd[k][4] - 8'h30), 2'(cmd[k][5] - 8'h30)}, {src_seen, dst_seen})
    end
    $display("done t_param");
  endtask
  task automatic t_refuse;
    int n;
    n = i_net_side.n_req;
    send("00PC30");
    expect_resp("00PS6");
    send("07PC20");
    send("00B");
    send("00PC201");
    send("00X");
    quiet(30);
    `CHK("ps_req count", n, i_net_side.n_req)
    `CHK("net count", 0, i_net_side.got.size())
    $display("done t_refuse");
  endtask
  task automatic t_bcast;
    int a, b;
    i_net_side.slow = 1'b1;
    send("00B+");
    send("00bV");
    quiet(10);
    `CHK("net count", 2, i_net_side.got.size())
    `CHK("net first", {8'h2B, 1'b1}, i_net_side.got[0])
    `CHK("net second", {8'h56, 1'b1}, i_net_side.got[1])
    slow_tx = 1'b1;
    fork
      begin
        i_net_side.reply(16'h3035, "V1", a);
        i_net_side.reply(16'h3037, "V2", b);
      end
      begin
        expect_resp("05V1");
        expect_resp("07V2");
      end
    join
    slow_tx = 1'b0;
    `CHK("replies", 4, a + b)
    $display("done t_bcast");
  endtask
  task automatic t_fill;
    int    n, m;
    string s;
    hold_tx = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    i_net_side.reply(16'h3039, {40{"R"}}, n);
    `CHK("fill", relay_pkg::FIFO_DEPTH, n)
    s = "09";
    repeat (n) s = {s, "R"};
    s = {s, "Z"};
    hold_tx = 1'b0;
    fork
      i_net_side.reply(16'h3039, "Z", m);
      expect_resp(s);
    join
    `CHK("fill tail", 1, m)
    $display("done t_fill");
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #600_000;
    errors++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    host_rx = '0;
    host_rx_valid = 1'b0;
    host_tx_ready = 1'b1;
    hold_tx = 1'b0;
    slow_tx = 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK("reset outs", 5'h08, {host_rx_ready, net_rx_ready, host_tx_valid, net_tx_valid, ps_req})
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("ready after reset", 1'b1, host_rx_ready)
    t_param();
    t_refuse();
    t_bcast();
    t_fill();
    close_out();
  end
endmodule
